// file: rtl/cpc_pkg.sv
// constants, field layouts and carrier types for the comparator pair control
// assumes a 32-bit axi4-lite register bus, one byte register per word
package cpc_pkg;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] IDX_CTRL0 = 4'h0;
  localparam logic [3:0] IDX_CTRL1 = 4'h1;
  localparam logic [3:0] IDX_MUX0 = 4'h2;
  localparam logic [3:0] IDX_MUX1 = 4'h3;
  localparam logic [3:0] IDX_ROUTE = 4'h4;
  localparam logic [3:0] IDX_SCALE = 4'h5;
  localparam logic [3:0] IDX_RANGE = 4'h6;
  localparam logic [3:0] IDX_STATUS = 4'h7;
  localparam logic [3:0] IDX_CURR = 4'h8;
  localparam logic [3:0] IDX_TRIM = 4'h9;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // writable bits per register, reserved bits stay zero
  localparam logic [7:0] MASK_CTRL = 8'hF7;
  localparam logic [7:0] MASK_MUX = 8'h3F;
  localparam logic [7:0] MASK_ROUTE = 8'h03;
  localparam logic [7:0] MASK_SCALE = 8'h3F;
  localparam logic [7:0] MASK_RANGE = 8'h1F;
  localparam logic [7:0] MASK_CURR = 8'hC3;
  localparam logic [7:0] MASK_TRIM = 8'h0F;
  localparam int unsigned WEN_BIT = 4;
  localparam int unsigned CS_EN_BIT = 7;
  localparam int unsigned CS_COMB_BIT = 6;
  localparam int unsigned ST_C1 = 5;
  localparam int unsigned ST_C0 = 4;
  localparam int unsigned ST_RF = 2;
  localparam int unsigned ST_F1 = 1;
  localparam int unsigned ST_F0 = 0;
  // negative input codes
  localparam logic [2:0] NEG_PIN0 = 3'h0;
  localparam logic [2:0] NEG_PIN1 = 3'h1;
  localparam logic [2:0] NEG_PIN3 = 3'h2;
  localparam logic [2:0] NEG_PIN5 = 3'h3;
  localparam logic [2:0] NEG_PIN7 = 3'h4;
  localparam logic [2:0] NEG_BANDGAP = 3'h6;
  localparam logic [2:0] NEG_SCALER = 3'h7;
  // vector offsets relative to the block base
  localparam logic [2:0] VEC_COMP0 = 3'h0;
  localparam logic [2:0] VEC_COMP1 = 3'h2;
  localparam logic [2:0] VEC_RANGE = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    EDGE_TOGGLE = 2'h0, EDGE_RSVD = 2'h1, EDGE_FALL = 2'h2, EDGE_RISE = 2'h3
  } cpc_edge_type;
  typedef enum logic [1:0] {
    RNG_ABOVE = 2'h0, RNG_INSIDE = 2'h1, RNG_BELOW = 2'h2, RNG_OUTSIDE = 2'h3
  } cpc_range_type;
  typedef struct packed {
    logic [1:0] edge_mode;
    logic [1:0] irq_level;
    logic rsvd;
    logic [1:0] hyst;
    logic enable;
  } cpc_ctrl_type;
  typedef struct packed {
    logic enable;
    logic [1:0] hyst;
    logic [2:0] pos_sel;
    logic [7:0] neg_pin;
    logic neg_bandgap;
    logic neg_scaler;
    logic [7:0] source_pin;
  } cpc_analog_type;
  typedef struct packed {
    logic req;
    logic [1:0] level;
  } cpc_irq_type;
endpackage

// file: rtl/cpc_edge.sv
// synchroniser and edge selector for one comparator output
// assumes raw is asynchronous to aclk
`timescale 1ns/1ps
module cpc_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic raw,
  input cpc_pkg::cpc_edge_type edge_mode,
  output logic level,
  output logic event_o
);
  logic meta_r;
  logic level_r;
  logic prev_r;
  logic event_r;
  logic hit;

  // two-stage synchroniser, only level_r reads meta_r
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      level_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= raw;
      level_r <= meta_r;
      prev_r <= level_r;
    end
  end

  // edge selection, reserved mode gives nothing
  always_comb begin
    case (edge_mode)
      cpc_pkg::EDGE_TOGGLE: hit = level_r ^ prev_r;
      cpc_pkg::EDGE_FALL: hit = prev_r & ~level_r;
      cpc_pkg::EDGE_RISE: hit = level_r & ~prev_r;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_r <= 1'b0;
    end else begin
      event_r <= hit;
    end
  end

  assign level = level_r;
  assign event_o = event_r;
endmodule

// file: rtl/cpc_top.sv
// comparator pair control: registers, routing, window state and flags
// assumes axi4-lite master, analog comparators and interrupt controller outside
//
// Summary of operation
// - negative selector decodes to pins 0,1,3,5,7, reserved, bandgap, scaler.
// - routing bit 1 drives comparator one output onto pin 6.
// - routing bit 0 drives comparator zero output onto pin 7.
// - six-bit scale factor held and presented to the supply scaler.
// - window enable bit 4 puts both comparators in window operation.
// - window condition 00 above, 01 inside, 10 below, 11 outside.
// - nonzero window level enables window request at that level.
// - with window enabled, status 7:6 report current window state.
// - status bits 5 and 4 show comparator one and zero levels.
// - status bit 2 sets when the window state enters the chosen condition.
// - window flag clears on its vector or a written one.
// - status bit 1 sets on comparator one edge, clears by vector or one.
// - status bit 0 sets on comparator zero edge, clears by vector or one.
// - current control bit 7 enables the constant current source.
// - current control bit 6 combines sources, doubling each output.
// - source output bits route current to the negative selected pin.
// - four-bit writable source trim value in bits 3:0.
// - vectors at 0x00 comparator zero, 0x02 one, 0x04 window.
// - edge mode 00 toggle, 10 falling, 11 rising, 01 reserved.
// - events follow flag conditions whether or not interrupts enabled.
`timescale 1ns/1ps
module cpc_top #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic comp_zero_in,
  input wire logic comp_one_in,
  output cpc_pkg::cpc_analog_type analog_zero,
  output cpc_pkg::cpc_analog_type analog_one,
  output logic [5:0] supply_scale_factor,
  output logic source_enable,
  output logic combine_sources,
  output logic [3:0] source_trim_value,
  output logic pin6_data,
  output logic pin6_drive,
  output logic pin7_data,
  output logic pin7_drive,
  output logic comp_zero_event,
  output logic comp_one_event,
  output logic range_event,
  output cpc_pkg::cpc_irq_type comp_zero_irq,
  output cpc_pkg::cpc_irq_type comp_one_irq,
  output cpc_pkg::cpc_irq_type range_irq,
  input wire logic vector_taken,
  input wire logic [2:0] vector_offset
);
  cpc_pkg::cpc_ctrl_type ctrl0_r;
  cpc_pkg::cpc_ctrl_type ctrl1_r;
  logic [7:0] mux0_r;
  logic [7:0] mux1_r;
  logic [7:0] route_r;
  logic [7:0] scale_r;
  logic [7:0] range_r;
  logic [7:0] curr_r;
  logic [7:0] trim_r;
  logic [2:0] flags_r;
  logic aw_held_r;
  logic w_held_r;
  logic [3:0] aw_idx_r;
  logic [7:0] wbyte_r;
  logic wlane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic do_wr;
  logic [3:0] ar_idx;
  logic [7:0] rd_byte;
  logic lvl0;
  logic lvl1;
  logic evt0;
  logic evt1;
  cpc_pkg::cpc_range_type rstate;
  logic rmatch;
  logic rmatch_prev_r;
  logic range_event_r;
  logic [2:0] clr_w1;
  logic [2:0] clr_vec;
  logic [7:0] status;

  ////////////////////////////////////////////////////////////////////////
  // comparator output synchronisers and edge detection
  cpc_edge u_edge0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(comp_zero_in),
    .edge_mode(cpc_pkg::cpc_edge_type'(ctrl0_r.edge_mode)),
    .level(lvl0),
    .event_o(evt0)
  );

  cpc_edge u_edge1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(comp_one_in),
    .edge_mode(cpc_pkg::cpc_edge_type'(ctrl1_r.edge_mode)),
    .level(lvl1),
    .event_o(evt1)
  );

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write side
  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign do_wr = aw_held_r && w_held_r && !bvalid_r;

  // address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= 4'h0;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held_r <= 1'b1;
        aw_idx_r <= awaddr[5:2];
      end else if (do_wr) begin
        aw_held_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_r <= 1'b1;
        wbyte_r <= wdata[7:0];
        wlane_r <= wstrb[0];
      end else if (do_wr) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write response, slverr outside the map
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= cpc_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r <= (aw_idx_r > cpc_pkg::IDX_TRIM) ? cpc_pkg::RESP_SLVERR : cpc_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  ////////////////////////////////////////////////////////////////////////
  // control registers, reserved bits masked off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_r <= cpc_pkg::RST_BYTE;
      ctrl1_r <= cpc_pkg::RST_BYTE;
      mux0_r <= cpc_pkg::RST_BYTE;
      mux1_r <= cpc_pkg::RST_BYTE;
      route_r <= cpc_pkg::RST_BYTE;
      scale_r <= cpc_pkg::RST_BYTE;
      range_r <= cpc_pkg::RST_BYTE;
      curr_r <= cpc_pkg::RST_BYTE;
      trim_r <= cpc_pkg::RST_BYTE;
    end else if (do_wr && wlane_r) begin
      case (aw_idx_r)
        cpc_pkg::IDX_CTRL0: ctrl0_r <= wbyte_r & cpc_pkg::MASK_CTRL;
        cpc_pkg::IDX_CTRL1: ctrl1_r <= wbyte_r & cpc_pkg::MASK_CTRL;
        cpc_pkg::IDX_MUX0: mux0_r <= wbyte_r & cpc_pkg::MASK_MUX;
        cpc_pkg::IDX_MUX1: mux1_r <= wbyte_r & cpc_pkg::MASK_MUX;
        cpc_pkg::IDX_ROUTE: route_r <= wbyte_r & cpc_pkg::MASK_ROUTE;
        cpc_pkg::IDX_SCALE: scale_r <= wbyte_r & cpc_pkg::MASK_SCALE;
        cpc_pkg::IDX_RANGE: range_r <= wbyte_r & cpc_pkg::MASK_RANGE;
        cpc_pkg::IDX_CURR: curr_r <= wbyte_r & cpc_pkg::MASK_CURR;
        cpc_pkg::IDX_TRIM: trim_r <= wbyte_r & cpc_pkg::MASK_TRIM;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // window state: zero is upper threshold, one is lower
  always_comb begin
    case ({lvl0, lvl1})
      2'b11: rstate = cpc_pkg::RNG_ABOVE;
      2'b01: rstate = cpc_pkg::RNG_INSIDE;
      2'b00: rstate = cpc_pkg::RNG_BELOW;
      default: rstate = cpc_pkg::RNG_OUTSIDE;
    endcase
  end

  // condition chosen by the window condition field
  always_comb begin
    case (range_r[3:2])
      2'b00: rmatch = (rstate == cpc_pkg::RNG_ABOVE);
      2'b01: rmatch = (rstate == cpc_pkg::RNG_INSIDE);
      2'b10: rmatch = (rstate == cpc_pkg::RNG_BELOW);
      default: rmatch = (rstate != cpc_pkg::RNG_INSIDE);
    endcase
  end

  // window event on entry into the chosen condition
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rmatch_prev_r <= 1'b0;
      range_event_r <= 1'b0;
    end else begin
      rmatch_prev_r <= rmatch && range_r[cpc_pkg::WEN_BIT];
      range_event_r <= rmatch && range_r[cpc_pkg::WEN_BIT] && !rmatch_prev_r;
    end
  end

  assign comp_zero_event = evt0;
  assign comp_one_event = evt1;
  assign range_event = range_event_r;

  ////////////////////////////////////////////////////////////////////////
  // flags: set wins over vector or written-one clear
  assign clr_w1 = (do_wr && wlane_r && aw_idx_r == cpc_pkg::IDX_STATUS) ? wbyte_r[2:0] : 3'h0;
  assign clr_vec[cpc_pkg::ST_F0] = vector_taken && vector_offset == cpc_pkg::VEC_COMP0;
  assign clr_vec[cpc_pkg::ST_F1] = vector_taken && vector_offset == cpc_pkg::VEC_COMP1;
  assign clr_vec[cpc_pkg::ST_RF] = vector_taken && vector_offset == cpc_pkg::VEC_RANGE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= 3'h0;
    end else begin
      flags_r[cpc_pkg::ST_F0] <= evt0 |
          (flags_r[cpc_pkg::ST_F0] & ~clr_w1[0] & ~clr_vec[0]);
      flags_r[cpc_pkg::ST_F1] <= evt1 |
          (flags_r[cpc_pkg::ST_F1] & ~clr_w1[1] & ~clr_vec[1]);
      flags_r[cpc_pkg::ST_RF] <= range_event_r |
          (flags_r[cpc_pkg::ST_RF] & ~clr_w1[2] & ~clr_vec[2]);
    end
  end

  // requests to the interrupt controller
  assign comp_zero_irq.req = flags_r[cpc_pkg::ST_F0] && ctrl0_r.irq_level != 2'h0;
  assign comp_zero_irq.level = ctrl0_r.irq_level;
  assign comp_one_irq.req = flags_r[cpc_pkg::ST_F1] && ctrl1_r.irq_level != 2'h0;
  assign comp_one_irq.level = ctrl1_r.irq_level;
  assign range_irq.req = flags_r[cpc_pkg::ST_RF] && range_r[1:0] != 2'h0;
  assign range_irq.level = range_r[1:0];

  ////////////////////////////////////////////////////////////////////////
  // status composition
  always_comb begin
    status = 8'h00;
    if (range_r[cpc_pkg::WEN_BIT]) begin
      status[7:6] = rstate;
    end
    status[cpc_pkg::ST_C1] = lvl1;
    status[cpc_pkg::ST_C0] = lvl0;
    status[2:0] = flags_r;
  end

  // read mux
  assign ar_idx = araddr[5:2];
  always_comb begin
    case (ar_idx)
      cpc_pkg::IDX_CTRL0: rd_byte = ctrl0_r;
      cpc_pkg::IDX_CTRL1: rd_byte = ctrl1_r;
      cpc_pkg::IDX_MUX0: rd_byte = mux0_r;
      cpc_pkg::IDX_MUX1: rd_byte = mux1_r;
      cpc_pkg::IDX_ROUTE: rd_byte = route_r;
      cpc_pkg::IDX_SCALE: rd_byte = scale_r;
      cpc_pkg::IDX_RANGE: rd_byte = range_r;
      cpc_pkg::IDX_STATUS: rd_byte = status;
      cpc_pkg::IDX_CURR: rd_byte = curr_r;
      cpc_pkg::IDX_TRIM: rd_byte = trim_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // read channel, one read under way
  assign arready = !rvalid_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= cpc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_byte};
      rresp_r <= (ar_idx > cpc_pkg::IDX_TRIM) ? cpc_pkg::RESP_SLVERR : cpc_pkg::RESP_OKAY;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  ////////////////////////////////////////////////////////////////////////
  // negative selector decode to one-hot pin, bandgap or scaler
  function automatic logic [9:0] neg_decode(input logic [2:0] code);
    logic [9:0] d;
    d = 10'h000;
    case (code)
      cpc_pkg::NEG_PIN0: d[0] = 1'b1;
      cpc_pkg::NEG_PIN1: d[1] = 1'b1;
      cpc_pkg::NEG_PIN3: d[3] = 1'b1;
      cpc_pkg::NEG_PIN5: d[5] = 1'b1;
      cpc_pkg::NEG_PIN7: d[7] = 1'b1;
      cpc_pkg::NEG_BANDGAP: d[8] = 1'b1;
      cpc_pkg::NEG_SCALER: d[9] = 1'b1;
      default: d = 10'h000;
    endcase
    return d;
  endfunction

  // analog controls registered toward the comparators
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_zero <= '0;
      analog_one <= '0;
    end else begin
      analog_zero.enable <= ctrl0_r.enable;
      analog_zero.hyst <= ctrl0_r.hyst;
      analog_zero.pos_sel <= mux0_r[5:3];
      {analog_zero.neg_scaler, analog_zero.neg_bandgap, analog_zero.neg_pin} <=
          neg_decode(mux0_r[2:0]);
      // only port pins take the source, internal inputs cut off
      analog_zero.source_pin <= curr_r[0] ? 8'(neg_decode(mux0_r[2:0])) : 8'h00;
      analog_one.enable <= ctrl1_r.enable;
      analog_one.hyst <= ctrl1_r.hyst;
      analog_one.pos_sel <= mux1_r[5:3];
      {analog_one.neg_scaler, analog_one.neg_bandgap, analog_one.neg_pin} <=
          neg_decode(mux1_r[2:0]);
      analog_one.source_pin <= curr_r[1] ? 8'(neg_decode(mux1_r[2:0])) : 8'h00;
    end
  end

  // pin routing and supply, source outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin6_data <= 1'b0;
      pin6_drive <= 1'b0;
      pin7_data <= 1'b0;
      pin7_drive <= 1'b0;
      supply_scale_factor <= 6'h00;
      source_enable <= 1'b0;
      combine_sources <= 1'b0;
      source_trim_value <= 4'h0;
    end else begin
      pin6_drive <= route_r[1];
      pin6_data <= route_r[1] & lvl1;
      pin7_drive <= route_r[0];
      pin7_data <= route_r[0] & lvl0;
      supply_scale_factor <= scale_r[5:0];
      source_enable <= curr_r[cpc_pkg::CS_EN_BIT];
      combine_sources <= curr_r[cpc_pkg::CS_COMB_BIT];
      source_trim_value <= trim_r[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  neg_decode_a: assert property (mux0_r[2:0] == 3'h2 |=> analog_zero.neg_pin == 8'h08)
    else $error("negative select code 010 not on pin 3");
  route_one_a: assert property (route_r[1] |=> pin6_drive && pin6_data == $past(lvl1))
    else $error("comparator one not on pin 6");
  route_zero_a: assert property (!route_r[0] |=> !pin7_drive && !pin7_data)
    else $error("pin 7 driven while routing off");
  scale_write_a: assert property (do_wr && wlane_r && aw_idx_r == 4'h5
      |=> ##1 supply_scale_factor == $past(wbyte_r[5:0], 2))
    else $error("scale factor not presented");
  state_hide_a: assert property (!range_r[4] |-> status[7:6] == 2'h0)
    else $error("window state shown while disabled");
  rise_event_a: assert property ($rose(lvl0) && ctrl0_r.edge_mode == 2'h3 |=> evt0)
    else $error("rising edge missed");
  flag_set_a: assert property (evt1 |=> flags_r[1])
    else $error("comparator one flag not set");
  vec_clear_a: assert property (flags_r[2] && vector_taken && vector_offset == 3'h4
      && !range_event_r |=> !flags_r[2])
    else $error("window flag not cleared by vector");
  w1c_clear_a: assert property (flags_r[0] && clr_w1[0] && !evt0 |=> !flags_r[0])
    else $error("written one did not clear flag");
  source_route_a: assert property (curr_r[0] && mux0_r[2:0] == 3'h3
      |=> analog_zero.source_pin == 8'h20)
    else $error("source not on selected pin");

  range_flag_c: cover property (range_event_r ##1 flags_r[2]);
  comp_flag_c: cover property (evt0 ##1 flags_r[0] ##[1:40] clr_vec[0]);
  rw_bus_c: cover property (bvalid && bready ##[1:20] rvalid && rready);
endmodule

// file: testbench/comparator_pair_control_tb_top.sv
// self-checking bench for the comparator pair control block
// assumes cpc_top with its default address width and the cpc_pkg constants
`timescale 1ns/1ps
module comparator_pair_control_tb_top;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, comp_zero_in, comp_one_in;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot, vector_offset;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, source_trim_value;
  logic [1:0] bresp, rresp, r, md, v;
  logic [5:0] supply_scale_factor;
  logic source_enable, combine_sources, pin6_data, pin6_drive, pin7_data, pin7_drive;
  logic comp_zero_event, comp_one_event, range_event, vector_taken;
  cpc_pkg::cpc_analog_type analog_zero, analog_one;
  cpc_pkg::cpc_irq_type comp_zero_irq, comp_one_irq, range_irq;
  int n_errors, samples_checked, ev0, ev1, evr;
  logic [7:0] wv [10];

  cpc_top i_dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .comp_zero_in, .comp_one_in, .analog_zero,
    .analog_one, .supply_scale_factor, .source_enable, .combine_sources,
    .source_trim_value, .pin6_data, .pin6_drive, .pin7_data, .pin7_drive,
    .comp_zero_event, .comp_one_event, .range_event, .comp_zero_irq, .comp_one_irq,
    .range_irq, .vector_taken, .vector_offset);

  ////////////////////////////////////////////////////////////////////////////////
  // clock and event pulse counters
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (comp_zero_event === 1'b1) ev0++;
    if (comp_one_event === 1'b1) ev1++;
    if (range_event === 1'b1) evr++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // verdict, comparison and bus tasks
  task automatic finish_test();
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // axi write: address and data offered together, each dropped when taken
  task automatic wr(input logic [3:0] idx, input logic [7:0] val);
    int n;
    n = 0;
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h00_0000, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n > 100) begin
        n_errors++;
        finish_test();
      end
    end while (!(bvalid === 1'b1 && bready));
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // axi read: result lands in d and r
  task automatic rd(input logic [3:0] idx);
    int n;
    n = 0;
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n > 100) begin
        n_errors++;
        finish_test();
      end
    end while (!(rvalid === 1'b1 && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic logic [7:0] mk(input int i);
    case (i)
      0, 1: return cpc_pkg::MASK_CTRL;
      2, 3: return cpc_pkg::MASK_MUX;
      4: return cpc_pkg::MASK_ROUTE;
      5: return cpc_pkg::MASK_SCALE;
      6: return cpc_pkg::MASK_RANGE;
      8: return cpc_pkg::MASK_CURR;
      9: return cpc_pkg::MASK_TRIM;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] negpin(input logic [2:0] c);
    case (c)
      3'h0: return 8'h01;
      3'h1: return 8'h02;
      3'h2: return 8'h08;
      3'h3: return 8'h20;
      3'h4: return 8'h80;
      default: return 8'h00;
    endcase
  endfunction

  // zero is the upper threshold, one the lower
  function automatic logic [1:0] wst(input logic z, input logic o);
    case ({z, o})
      2'b11: return 2'h0;
      2'b01: return 2'h1;
      2'b00: return 2'h2;
      default: return 2'h3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, comp_zero_in, comp_one_in} = 8'h00;
    {awaddr, araddr, awprot, arprot, vector_offset, wdata} = 0;
    wstrb = 4'hF;
    vector_taken = 1'b0;
    {n_errors, samples_checked, ev0, ev1, evr} = 0;
    void'($urandom(69880));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped indices answer with an error
    for (int i = 0; i < 13; i++) begin
      rd(i[3:0]);
      chk("reset read", 32'h0000_0000, d);
      chk("read resp", 32'((i > 9) ? cpc_pkg::RESP_SLVERR : cpc_pkg::RESP_OKAY), 32'(r));
    end
    // random writes read back through the writable masks
    for (int i = 0; i < 10; i++) begin
      if (i != 7) begin
        wv[i] = 8'($urandom) & mk(i);
        wr(i[3:0], wv[i]);
        rd(i[3:0]);
        chk("readback", 32'(wv[i]), d);
      end
    end
    wr(4'hC, 8'hFF);
    chk("unmapped write resp", 32'(cpc_pkg::RESP_SLVERR), 32'(r));
    chk("scale factor", 32'(wv[5][5:0]), 32'(supply_scale_factor));
    chk("trim", 32'(wv[9][3:0]), 32'(source_trim_value));
    chk("source enable", 32'(wv[8][7]), 32'(source_enable));
    chk("combine", 32'(wv[8][6]), 32'(combine_sources));
    chk("ctrl to analog", 32'({wv[0][2:0], wv[1][2:0]}),
        32'({analog_zero.hyst, analog_zero.enable, analog_one.hyst, analog_one.enable}));
    // every negative code with the current source routed to both comparators
    wr(cpc_pkg::IDX_CURR, 8'h83);
    for (int c = 0; c < 8; c++) begin
      wv[2] = {2'b00, 3'($urandom), c[2:0]};
      wr(cpc_pkg::IDX_MUX0, wv[2]);
      wr(cpc_pkg::IDX_MUX1, wv[2]);
      chk("neg pin", 32'({2{negpin(c[2:0])}}),
          32'({analog_zero.neg_pin, analog_one.neg_pin}));
      chk("neg internal", 32'({c == 6, c == 7}),
          32'({analog_zero.neg_bandgap, analog_zero.neg_scaler}));
      chk("source pin", 32'({2{negpin(c[2:0])}}),
          32'({analog_zero.source_pin, analog_one.source_pin}));
      chk("pos select", 32'({2{wv[2][5:3]}}), 32'({analog_zero.pos_sel, analog_one.pos_sel}));
    end
    // both comparators in every edge mode, outputs routed to pins
    wr(cpc_pkg::IDX_ROUTE, 8'h03);
    wr(cpc_pkg::IDX_RANGE, 8'h00);
    chk("pin drive", 32'h0000_0003, 32'({pin6_drive, pin7_drive}));
    for (int c = 0; c < 2; c++) begin
      for (int m = 0; m < 4; m++) begin
        md = (m == 0) ? 2'h0 : (m == 1) ? 2'h2 : (m == 2) ? 2'h3 : 2'h1;
        wr(4'(c), {md, 2'b01, 4'h0});
        wr(cpc_pkg::IDX_STATUS, 8'h07);
        ev0 = 0;
        ev1 = 0;
        for (int s = 1; s >= 0; s--) begin
          if (c == 0) comp_zero_in <= s[0];
          else comp_one_in <= s[0];
          repeat (6) @(posedge aclk);
          chk("pin level", 32'(s[0]), 32'(c ? pin6_data : pin7_data));
          rd(cpc_pkg::IDX_STATUS);
          chk("level", 32'(s[0]), 32'(d[4 + c]));
        end
        chk("event count", (m == 0) ? 2 : (m == 3) ? 0 : 1, c ? ev1 : ev0);
        chk("edge irq", (m == 3) ? 32'h0000_0001 : 32'h0000_0005,
            32'(c ? comp_one_irq : comp_zero_irq));
        chk("edge flag", 32'(m != 3), 32'(d[c]));
        vector_offset <= 3'(2 * c);
        vector_taken <= 1'b1;
        @(posedge aclk);
        vector_taken <= 1'b0;
        rd(cpc_pkg::IDX_STATUS);
        chk("flag after vector", 0, 32'(d[c]));
      end
    end
    // window states for all input pairs, ending on entry into inside
    wr(cpc_pkg::IDX_RANGE, 8'h15);
    wr(cpc_pkg::IDX_STATUS, 8'h04);
    evr = 0;
    for (int k = 0; k < 4; k++) begin
      v = 2'(k + 2);
      {comp_zero_in, comp_one_in} <= v;
      repeat (6) @(posedge aclk);
      rd(cpc_pkg::IDX_STATUS);
      chk("range state", 32'(wst(v[1], v[0])), 32'(d[7:6]));
    end
    chk("range flag", 1, 32'(d[2]));
    chk("range events", 1, evr);
    chk("range irq", 32'h0000_0005, 32'(range_irq));
    wr(cpc_pkg::IDX_STATUS, 8'h04);
    rd(cpc_pkg::IDX_STATUS);
    chk("range flag cleared", 0, 32'(d[2]));
    // below condition, flag cleared by its vector
    wr(cpc_pkg::IDX_RANGE, 8'h19);
    {comp_zero_in, comp_one_in} <= 2'b00;
    repeat (6) @(posedge aclk);
    rd(cpc_pkg::IDX_STATUS);
    chk("below flag", 32'h0000_0084, 32'(d[7:0] & 8'hC4));
    vector_offset <= cpc_pkg::VEC_RANGE;
    vector_taken <= 1'b1;
    @(posedge aclk);
    vector_taken <= 1'b0;
    rd(cpc_pkg::IDX_STATUS);
    chk("range flag vector", 0, 32'(d[2]));
    finish_test();
  end
endmodule
